// ==== bench/dscp_chk.sv ====
// wire-level assertions on the link between host and device ends
`timescale 1ns/1ns
module dscp_chk (
    // clocks and reset
    input wire logic CLOCK_IN,
    input wire logic LINK_CLK_IN,
    input wire logic RST_IN,
    // link wires
    input wire logic scl,
    input wire logic cs,
    input wire logic h_sda_oe,
    input wire logic d_sda_oe,
    input wire logic sdo
);
    // select high long enough for the synchronisers to settle
    sequence s_cs_idle;
        cs [*8];
    endsequence
    sequence s_start;
        scl && $rose(h_sda_oe);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $fell(h_sda_oe);
    endsequence

    property p_ack_hold; @(posedge LINK_CLK_IN) disable iff (RST_IN)
        d_sda_oe && scl |=> d_sda_oe || !scl; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack cut");
    property p_oe_low; @(posedge LINK_CLK_IN) disable iff (RST_IN)
        $changed(d_sda_oe) |-> !scl; endproperty
    a_oe_low: assert property (p_oe_low) else $error("sda moved");
    property p_spi_sda; @(posedge LINK_CLK_IN) disable iff (RST_IN)
        !cs |-> !d_sda_oe; endproperty
    a_spi_sda: assert property (p_spi_sda) else $error("sdi driven");
    property p_sdo_idle; @(posedge LINK_CLK_IN) disable iff (RST_IN)
        s_cs_idle |-> !sdo; endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo busy");
    property p_sdo_fall; @(posedge LINK_CLK_IN) disable iff (RST_IN)
        $changed(sdo) && !cs |-> !scl; endproperty
    a_sdo_fall: assert property (p_sdo_fall) else $error("sdo edge");
    property p_scl_hi; @(posedge CLOCK_IN) disable iff (RST_IN)
        $rose(scl) |-> scl [*4]; endproperty
    a_scl_hi: assert property (p_scl_hi) else $error("scl short");
    property p_start; @(posedge CLOCK_IN) disable iff (RST_IN)
        s_start |-> ##[1:16] !scl; endproperty
    a_start: assert property (p_start) else $error("no clock");
    property p_stop; @(posedge CLOCK_IN) disable iff (RST_IN)
        s_stop |=> scl [*4]; endproperty
    a_stop: assert property (p_stop) else $error("stop broken");
endmodule

// ==== bench/dscp_tb_top.sv ====
// bench: host end drives the device end over the link
`timescale 1ns/1ns
module dscp_tb_top import dscp_pkg::*; ;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic vld = 1'b0;
    dscp_op_t op = OP_WRITE;
    logic [7:0] adr = 8'h00;
    logic [7:0] dat = 8'h00;
    logic rdy, rv, nack, hlock, dlock, acq, re;
    logic [7:0] rdat;
    logic [24:0] fractional_value;
    logic [11:0] intv;
    logic [3:0] cp;
    logic [6:0] rc;
    logic [2:0] od;
    logic [NREG*8-1:0] rf;
    logic [7:0] wa [9] = '{8'h03, 8'h02, 8'h01, 8'h06, 8'h07, 8'h09,
        8'h0A, 8'h05, 8'h1C};
    logic [7:0] wd [9] = '{8'h01, 8'hA5, 8'h5A, 8'h2E, 8'h0B, 8'hF0,
        8'h7F, 8'h10, 8'h04};
    wire [51:0] app = {fractional_value, intv, cp, rc, re, od};
    int failures = 0;
    int check_count = 0;
    int acq_n = 0;
    int cyc = 0;

    dscp_if dscp_if_inst ();
    dscp_host dscp_host_inst (.CLOCK_IN(clk), .RST_IN(rst),
        .LINK(dscp_if_inst.host), .CMD_VALID_IN(vld), .CMD_READY_OUT(rdy),
        .CMD_OP_IN(op), .CMD_ADDR_IN(adr), .CMD_DATA_IN(dat),
        .RSP_VALID_OUT(rv), .RSP_DATA_OUT(rdat), .RSP_NACK_OUT(nack),
        .SPI_LOCKED_OUT(hlock));
    dscp_device dscp_device_inst (.LINK_CLK_IN(lclk), .RST_IN(rst),
        .LINK(dscp_if_inst.dev), .FRACTIONAL_VALUE_OUT(fractional_value), .INT_OUT(intv),
        .CP_CURRENT_OUT(cp), .REF_CTRL_OUT(rc), .REF_DIV_EN_OUT(re),
        .OUTPUT_DIVIDER_SETTING_OUT(od), .ACQ_START_OUT(acq),
        .SPI_LOCKED_OUT(dlock), .REG_FILE_OUT(rf));
    dscp_chk dscp_chk_inst (.CLOCK_IN(clk), .LINK_CLK_IN(lclk), .RST_IN(rst),
        .scl(dscp_if_inst.scl), .cs(dscp_if_inst.cs),
        .h_sda_oe(dscp_if_inst.h_sda_oe), .d_sda_oe(dscp_if_inst.d_sda_oe),
        .sdo(dscp_if_inst.sdo));

    initial forever #50 clk = ~clk;
    // odd offset keeps the link clock out of phase with the host clock
    initial begin
        #7;
        forever #24 lclk = ~lclk;
    end
    always @(negedge lclk) if (acq === 1'b1) acq_n++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            finish_test;
        end
    end

    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, s, e);
        end
    endtask
    task automatic do_rst;
        @(negedge clk);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
    endtask
    // device writes land before the response; the task then waits four more host clocks
    task automatic cmd(input dscp_op_t o, input logic [7:0] a, d);
        @(negedge clk);
        op = o;
        adr = a;
        dat = d;
        vld = 1'b1;
        while (rdy !== 1'b1)
            @(negedge clk);
        @(negedge clk);
        vld = 1'b0;
        while (rv !== 1'b1)
            @(negedge clk);
        repeat (4) @(negedge clk);
    endtask
    task automatic finish_test;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        do_rst;
        for (int i = 0; i < 9; i++) begin
            cmd(OP_WRITE, wa[i], wd[i]);
            chk(nack, 0);
            chk(rf[wa[i]*8 +: 8], wd[i]);
        end
        chk(app, 0);
        cmd(OP_WRITE, ACQ_TRIGGER_FRACTIONAL_VALUE_LOW_REG, 8'h3C);
        chk(acq_n, 1);
        chk(app, {25'h1A55A3C, 12'hB2E, 4'hF, 7'h7F, 1'b1, 3'h4});
        $display("test i2c write done");
        cmd(OP_READ, 8'h02, 8'h00);
        chk({nack, rdat}, 9'h0A5);
        cmd(OP_WRITE, LAST_SUB, 8'h77);
        chk(nack, 0);
        cmd(OP_WRITE, 8'h22, 8'h99);
        chk(nack, 1);
        cmd(OP_READ, LAST_SUB, 8'h00);
        chk(rdat, 8'h77);
        $display("test i2c read done");
        cmd(OP_LOCK, 8'h00, 8'h00);
        chk({hlock, dlock}, 2'b11);
        cmd(OP_WRITE, 8'h04, 8'hC3);
        chk(rf[39:32], 8'hC3);
        cmd(OP_READ, 8'h02, 8'h00);
        chk({nack, rdat}, 9'h0A5);
        cmd(OP_WRITE, 8'h22, 8'h55);
        cmd(OP_READ, 8'h22, 8'h00);
        chk(rdat, 8'h00);
        cmd(OP_WRITE, FRACTIONAL_VALUE_BYTE_THREE_REG, 8'h11);
        chk(fractional_value, 25'h1A55A3C);
        cmd(OP_WRITE, ACQ_TRIGGER_FRACTIONAL_VALUE_LOW_REG, 8'h22);
        chk(acq_n, 2);
        chk(fractional_value, 25'h1A51122);
        cmd(OP_LOCK, 8'h00, 8'h00);
        chk(dlock, 1);
        $display("test spi done");
        do_rst;
        repeat (4) @(negedge clk);
        chk({hlock, dlock, rf[61:0]}, 0);
        cmd(OP_WRITE, REF_DIV_EN_REG, 8'h10);
        chk({nack, rf[47:40]}, 9'h010);
        $display("test power cycle done");
        finish_test;
    end
endmodule

// ==== logic/dscp_device.sv ====
// device end: I2C/SPI slave with 34 byte registers and shadowed PLL settings
// Operation
// - address 1,select level,00000 is answered
// - first byte lsb: 1 read, 0 write
// - start is SDA fall, then MSB-first byte
// - matched address acknowledged on ninth pulse
// - mismatch releases bus, waits for start
// - second byte is starting subaddress
// - subaddress advances after every data byte (code: not after a read byte that the master nacks)
// - master ends every transfer with stop
// - stray start restarts address reception, stray stop returns to idle
// - invalid subaddress gets no acknowledge
// - powers up in I2C, unlocked
// - third select rising edge locks SPI
// - SPI lock held until power cycle
// - select low only during SPI frames
// - SPI write: D4, address, data, rising edges
// - SPI read: D4+address frame, then D5 frame
// - SPI data in on SDI, out on SDO
// - 34 eight-bit registers, both interfaces
// - PLL settings shadowed until trigger write
// - trigger register write starts acquisition
// - host writes fraction high to low, trigger last
// - trigger register holds fraction low byte
`timescale 1ns/1ns
module dscp_device
    import dscp_pkg::*;
(
    // link clock and power-on reset
    input wire logic LINK_CLK_IN,
    input wire logic RST_IN,
    // serial pins
    dscp_if.dev LINK,
    // applied PLL settings
    output logic [24:0] FRACTIONAL_VALUE_OUT,
    output logic [11:0] INT_OUT,
    output logic [3:0] CP_CURRENT_OUT,
    output logic [6:0] REF_CTRL_OUT,
    output logic REF_DIV_EN_OUT,
    output logic [2:0] OUTPUT_DIVIDER_SETTING_OUT,
    // status and live register contents
    output logic ACQ_START_OUT,
    output logic SPI_LOCKED_OUT,
    output logic [NREG*8-1:0] REG_FILE_OUT
);
    typedef struct packed {
        logic [1:0] scl_m;
        logic [1:0] sda_m;
        logic [1:0] cs_m;
        logic scl_p;
        logic sda_p;
        logic cs_p;
        dscp_dst_t st;
        logic [4:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic cmd_wr;
        logic [7:0] ptr;
        logic [7:0] rbyte;
        logic sda_oe;
        logic sdo;
        logic [1:0] cs_rises;
        logic spi;
        logic acq;
        logic [NREG-1:0][7:0] regs;
        logic [NREG-1:0][7:0] act;
    } dscp_dev_t;

    dscp_dev_t q;
    dscp_dev_t n;
    logic scl_s;
    logic sda_s;
    logic cs_s;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [6:0] own;
    logic wr_en;
    logic [5:0] wr_idx;
    logic [7:0] wr_dat;

    function automatic logic sub_ok(input logic [7:0] a);
        sub_ok = (a <= LAST_SUB);
    endfunction

    assign scl_s = q.scl_m[1];
    assign sda_s = q.sda_m[1];
    assign cs_s = ~q.cs_m[1];
    assign rise = scl_s & ~q.scl_p;
    assign fall = ~scl_s & q.scl_p;
    // both edges seen with SCL held high
    assign start = scl_s & q.scl_p & ~sda_s & q.sda_p;
    assign stop = scl_s & q.scl_p & sda_s & ~q.sda_p;
    assign own = I2C_ADDR_BASE | {1'b0, cs_s, 5'h00};

    always_comb begin
        n = q;
        wr_en = 1'b0;
        wr_idx = '0;
        wr_dat = '0;
        n.acq = 1'b0;
        n.scl_m = {q.scl_m[0], LINK.scl};
        n.sda_m = {q.sda_m[0], LINK.sda};
        n.cs_m = {q.cs_m[0], ~LINK.cs}; // inverted: reset reads idle-high
        n.scl_p = scl_s;
        n.sda_p = sda_s;
        n.cs_p = ~cs_s;
        // select pulses only count before the lock; nothing but reset undoes it
        if (!q.spi && cs_s && q.cs_p) begin
            n.cs_rises = q.cs_rises + 2'h1;
            if (q.cs_rises == LOCK_PULSES - 2'h1) begin
                n.spi = 1'b1;
            end
        end
        if (q.spi) begin
            n.sda_oe = 1'b0;
            if (cs_s) begin
                n.cnt = '0;
                n.sdo = 1'b0;
                n.rw = 1'b0;
                n.cmd_wr = 1'b0;
            end else if (rise && q.cnt != SPI_WR_BITS) begin
                n.sh = {q.sh[6:0], sda_s};
                n.cnt = q.cnt + 5'h01;
                if (q.cnt == BYTE_LAST) begin
                    n.rw = (n.sh == CMD_RD);
                    n.cmd_wr = (n.sh == CMD_WR);
                    n.rbyte = REG_RST;
                    if (n.rw && sub_ok(q.ptr)) begin
                        n.rbyte = q.regs[q.ptr[5:0]];
                    end
                end
                if (q.cnt == ADDR_LAST && q.cmd_wr) begin
                    n.ptr = n.sh;
                end
                if (q.cnt == DATA_LAST && q.cmd_wr && sub_ok(q.ptr)) begin
                    wr_en = 1'b1;
                    wr_idx = q.ptr[5:0];
                    wr_dat = n.sh;
                end
            end else if (fall && q.rw && q.cnt >= BYTE_BITS &&
                         q.cnt < SPI_RD_BITS) begin
                n.sdo = q.rbyte[7];
                n.rbyte = {q.rbyte[6:0], 1'b0};
            end
        end else if (start) begin
            n.st = D_ADDR;
            n.cnt = '0;
            n.sda_oe = 1'b0;
        end else if (stop) begin
            n.st = D_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (q.st)
                D_ADDR, D_SUB, D_WDATA: begin
                    if (rise) begin
                        n.sh = {q.sh[6:0], sda_s};
                        n.cnt = q.cnt + 5'h01;
                    end else if (fall && q.cnt == BYTE_BITS) begin
                        n.cnt = '0;
                        n.st = D_IDLE;
                        if (q.st == D_ADDR) begin
                            if (q.sh[7:1] == own) begin
                                n.rw = q.sh[0];
                                n.st = D_ACK_A;
                                n.sda_oe = 1'b1;
                            end
                        end else if (q.st == D_SUB) begin
                            if (sub_ok(q.sh)) begin
                                n.ptr = q.sh;
                                n.st = D_ACK_S;
                                n.sda_oe = 1'b1;
                            end
                        end else if (sub_ok(q.ptr)) begin
                            wr_en = 1'b1;
                            wr_idx = q.ptr[5:0];
                            wr_dat = q.sh;
                            n.ptr = q.ptr + 8'h01;
                            n.st = D_ACK_W;
                            n.sda_oe = 1'b1;
                        end
                    end
                end
                D_ACK_A, D_RNEXT: begin
                    if (fall) begin
                        n.sda_oe = 1'b0;
                        n.st = D_IDLE;
                        if (q.st == D_ACK_A && !q.rw) begin
                            n.st = D_SUB;
                        end else if (sub_ok(q.ptr)) begin
                            n.st = D_RDATA;
                            n.rbyte = q.regs[q.ptr[5:0]];
                            n.sda_oe = ~n.rbyte[7];
                            n.cnt = 5'h01;
                        end
                    end
                end
                D_ACK_S, D_ACK_W: begin
                    if (fall) begin
                        n.sda_oe = 1'b0;
                        n.st = D_WDATA;
                    end
                end
                D_RDATA: begin
                    if (fall) begin
                        if (q.cnt == BYTE_BITS) begin
                            n.sda_oe = 1'b0;
                            n.st = D_RACK;
                        end else begin
                            n.sda_oe = ~q.rbyte[6];
                            n.rbyte = {q.rbyte[6:0], 1'b0};
                            n.cnt = q.cnt + 5'h01;
                        end
                    end
                end
                D_RACK: begin
                    if (rise) begin
                        // master ack asks for the next register
                        if (!sda_s) begin
                            n.st = D_RNEXT;
                            n.ptr = q.ptr + 8'h01;
                        end else begin
                            n.st = D_IDLE;
                        end
                    end
                end
                default: begin
                    n.st = D_IDLE;
                end
            endcase
        end
        if (wr_en) begin
            n.regs[wr_idx] = wr_dat;
            if (wr_idx == ACQ_TRIGGER_FRACTIONAL_VALUE_LOW_REG) begin
                n.acq = 1'b1;
                for (int i = 0; i < NREG; i++) begin
                    if (DBUF_MASK[i]) begin
                        n.act[i] = n.regs[i];
                    end
                end
            end
        end
    end

    // reset stands for a power cycle: it alone clears the SPI lock
    always_ff @(posedge LINK_CLK_IN) begin
        if (RST_IN) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign LINK.d_sda_o = 1'b0;
    assign LINK.d_sda_oe = q.sda_oe;
    assign LINK.sdo = q.sdo;
    assign FRACTIONAL_VALUE_OUT = {q.act[FRACTIONAL_VALUE_TOP_REG][FRACTIONAL_VALUE_TOP_BIT],
                       q.act[FRACTIONAL_VALUE_BYTE_TWO_REG],
                       q.act[FRACTIONAL_VALUE_BYTE_THREE_REG],
                       q.act[ACQ_TRIGGER_FRACTIONAL_VALUE_LOW_REG]};
    assign INT_OUT = {q.act[INT_HIGH_REG][INT_HIGH_MSB:0],
                      q.act[INT_LOW_REG]};
    assign CP_CURRENT_OUT = q.act[CP_CURRENT_REG][CP_MSB:CP_LSB];
    assign REF_CTRL_OUT = q.act[REF_CTRL_REG][REF_CTRL_MSB:0];
    assign REF_DIV_EN_OUT = q.act[REF_DIV_EN_REG][REF_DIV_EN_BIT];
    assign OUTPUT_DIVIDER_SETTING_OUT = q.act[OUT_DIV_REG][OUT_DIV_MSB:0];
    assign ACQ_START_OUT = q.acq;
    assign SPI_LOCKED_OUT = q.spi;
    assign REG_FILE_OUT = q.regs;
endmodule

// ==== logic/dscp_host.sv ====
// host end: bus master that runs I2C or SPI register accesses
`timescale 1ns/1ns
module dscp_host
    import dscp_pkg::*;
(
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    // serial pins
    dscp_if.host LINK,
    // command
    input wire logic CMD_VALID_IN,
    output logic CMD_READY_OUT,
    input wire dscp_op_t CMD_OP_IN,
    input wire logic [7:0] CMD_ADDR_IN,
    input wire logic [7:0] CMD_DATA_IN,
    // response
    output logic RSP_VALID_OUT,
    output logic [7:0] RSP_DATA_OUT,
    output logic RSP_NACK_OUT,
    output logic SPI_LOCKED_OUT
);
    typedef struct packed {
        logic [1:0] sda_m;
        logic [1:0] sdo_m;
        dscp_hst_t st;
        dscp_op_t op;
        logic [3:0] div;
        logic [1:0] q4;
        logic [4:0] bidx;
        logic [2:0] step;
        logic [7:0] addr;
        logic [7:0] data;
        logic [23:0] sh;
        logic [7:0] rx;
        logic nack;
        logic frame;
        logic locked;
        logic scl;
        logic sda_oe;
        logic cs;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_nack;
    } dscp_host_t;

    dscp_host_t q;
    dscp_host_t n;
    logic tick;
    logic sda_s;
    logic sdo_s;
    logic [9:0] stp;
    dscp_kind_t kind;
    logic [7:0] byt;
    logic [2:0] stop_idx;
    logic [4:0] fbits;

    // i2c sequence: write = S A B D P, read = S A B Sr A' R P
    function automatic logic [9:0] i2c_step(input dscp_op_t op,
                                            input logic [2:0] s,
                                            input logic [7:0] a,
                                            input logic [7:0] d);
        logic [7:0] dev;
        dev = {I2C_ADDR_BASE | {1'b0, CS_IDLE, 5'h00}, 1'b0};
        case (s)
            3'h0: i2c_step = {K_START, 8'h00};
            3'h1: i2c_step = {K_TX, dev};
            3'h2: i2c_step = {K_TX, a};
            3'h3: i2c_step = (op == OP_READ) ? {K_START, 8'h00} : {K_TX, d};
            3'h4: i2c_step = (op == OP_READ) ? {K_TX, dev | 8'h01} :
                                               {K_STOP, 8'h00};
            3'h5: i2c_step = {K_RX, 8'h00};
            default: i2c_step = {K_STOP, 8'h00};
        endcase
    endfunction

    assign sda_s = q.sda_m[1];
    assign sdo_s = q.sdo_m[1];
    assign tick = (q.div == Q_CYCLES - 4'h1);
    assign stp = i2c_step(q.op, q.step, q.addr, q.data);
    assign kind = dscp_kind_t'(stp[9:8]);
    assign byt = stp[7:0];
    assign stop_idx = (q.op == OP_READ) ? 3'h6 : 3'h4;
    assign fbits = (q.op == OP_WRITE) ? SPI_WR_BITS : SPI_RD_BITS;

    always_comb begin
        n = q;
        n.rsp_valid = 1'b0;
        n.sda_m = {q.sda_m[0], LINK.sda};
        n.sdo_m = {q.sdo_m[0], LINK.sdo};
        // serial clock steps one phase per tick of this divider
        n.div = tick ? 4'h0 : q.div + 4'h1;
        case (q.st)
            H_IDLE: begin
                if (CMD_VALID_IN) begin
                    n.op = CMD_OP_IN;
                    n.addr = CMD_ADDR_IN;
                    n.data = CMD_DATA_IN;
                    n.step = '0;
                    n.q4 = '0;
                    n.bidx = '0;
                    n.nack = 1'b0;
                    n.frame = 1'b0;
                    n.rx = '0;
                    n.sh = {CMD_WR, CMD_ADDR_IN, CMD_DATA_IN};
                    if (CMD_OP_IN == OP_LOCK) begin
                        n.st = q.locked ? H_DONE : H_LOCK;
                    end else begin
                        n.st = q.locked ? H_CSLO : H_I2C;
                    end
                end
            end
            H_LOCK: begin
                if (tick) begin
                    n.cs = ~q.cs;
                    n.bidx = q.bidx + 5'h01;
                    if (q.bidx == LOCK_TOGGLES - 5'h01) begin
                        n.locked = 1'b1;
                        n.st = H_DONE;
                    end
                end
            end
            H_I2C: begin
                if (tick) begin
                    n.q4 = q.q4 + 2'h1;
                    case (q.q4)
                        2'h0: begin
                            n.scl = 1'b0;
                            n.sda_oe = (kind == K_STOP) ||
                                (kind == K_TX && q.bidx != BYTE_BITS &&
                                 !byt[~q.bidx[2:0]]);
                        end
                        2'h1: n.scl = 1'b1;
                        2'h2: begin
                            if (kind == K_START) n.sda_oe = 1'b1;
                            if (kind == K_STOP) n.sda_oe = 1'b0;
                            if (kind == K_TX && q.bidx == BYTE_BITS) begin
                                n.nack = sda_s;
                            end
                            if (kind == K_RX && q.bidx != BYTE_BITS) begin
                                n.rx = {q.rx[6:0], sda_s};
                            end
                        end
                        default: begin
                            if (kind != K_STOP) n.scl = 1'b0;
                            if ((kind == K_TX || kind == K_RX) &&
                                q.bidx != BYTE_BITS) begin
                                n.bidx = q.bidx + 5'h01;
                            end else begin
                                n.bidx = '0;
                                n.step = q.step + 3'h1;
                                if (kind == K_STOP) begin
                                    n.st = H_DONE;
                                end else if (kind == K_TX && q.nack) begin
                                    n.step = stop_idx;
                                end
                            end
                        end
                    endcase
                end
            end
            H_CSLO: begin
                if (tick) begin
                    n.cs = 1'b0;
                    n.st = H_SPI;
                    n.q4 = '0;
                    n.bidx = '0;
                end
            end
            H_SPI: begin
                if (tick) begin
                    n.q4 = q.q4 + 2'h1;
                    case (q.q4)
                        2'h0: begin
                            n.scl = 1'b0;
                            n.sda_oe = ~q.sh[23];
                        end
                        2'h1: n.scl = 1'b1;
                        2'h2: n.rx = {q.rx[6:0], sdo_s};
                        default: begin
                            n.scl = 1'b0;
                            n.sh = {q.sh[22:0], 1'b0};
                            n.bidx = q.bidx + 5'h01;
                            if (q.bidx == fbits - 5'h01) n.st = H_CSHI;
                        end
                    endcase
                end
            end
            H_CSHI: begin
                if (tick) begin
                    n.cs = 1'b1;
                    n.sda_oe = 1'b0;
                    n.st = H_DONE;
                    if (q.op == OP_READ && !q.frame) begin
                        n.frame = 1'b1;
                        n.sh = {CMD_RD, 16'h0000};
                        n.st = H_CSLO;
                    end
                end
            end
            H_DONE: begin
                n.scl = 1'b1;
                n.rsp_valid = 1'b1;
                n.rsp_data = q.rx;
                n.rsp_nack = q.nack;
                n.st = H_IDLE;
            end
            default: n.st = H_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            q <= '0;
            q.scl <= 1'b1;
            q.cs <= CS_IDLE;
        end else begin
            q <= n;
        end
    end

    assign LINK.scl = q.scl;
    assign LINK.cs = q.cs;
    assign LINK.h_sda_o = 1'b0;
    assign LINK.h_sda_oe = q.sda_oe;
    assign CMD_READY_OUT = (q.st == H_IDLE);
    assign RSP_VALID_OUT = q.rsp_valid;
    assign RSP_DATA_OUT = q.rsp_data;
    assign RSP_NACK_OUT = q.rsp_nack;
    assign SPI_LOCKED_OUT = q.locked;
endmodule

// ==== shared/dscp_if.sv ====
// serial pins between the control port and its bus master
`timescale 1ns/1ns
interface dscp_if;
    logic scl;
    logic cs;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic sda;
    logic sdo;

    // open-drain wire with pull-up
    assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

    modport host (output scl, cs, h_sda_o, h_sda_oe, input sda, sdo);
    modport dev (input scl, cs, sda, output d_sda_o, d_sda_oe, sdo);
endinterface

// ==== shared/dscp_pkg.sv ====
// shared constants and types for the dual serial control port
package dscp_pkg;
    localparam int NREG = 34;
    localparam logic [7:0] LAST_SUB = 8'h21;
    localparam logic [7:0] CMD_WR = 8'hD4;
    localparam logic [7:0] CMD_RD = 8'hD5;
    localparam logic [6:0] I2C_ADDR_BASE = 7'h40;
    localparam logic CS_IDLE = 1'b1;
    localparam logic [1:0] LOCK_PULSES = 2'h3;
    localparam logic [4:0] LOCK_TOGGLES = 5'h06;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] BYTE_LAST = 5'h07;
    localparam logic [4:0] ADDR_LAST = 5'h0F;
    localparam logic [4:0] DATA_LAST = 5'h17;
    localparam logic [4:0] SPI_RD_BITS = 5'h10;
    localparam logic [4:0] SPI_WR_BITS = 5'h18;
    localparam logic [3:0] Q_CYCLES = 4'h4;
    localparam logic [7:0] REG_RST = 8'h00;
    // register indices
    localparam logic [5:0] ACQ_TRIGGER_FRACTIONAL_VALUE_LOW_REG = 6'h00;
    localparam logic [5:0] FRACTIONAL_VALUE_BYTE_THREE_REG = 6'h01;
    localparam logic [5:0] FRACTIONAL_VALUE_BYTE_TWO_REG = 6'h02;
    localparam logic [5:0] FRACTIONAL_VALUE_TOP_REG = 6'h03;
    localparam logic [5:0] REF_DIV_EN_REG = 6'h05;
    localparam logic [5:0] INT_LOW_REG = 6'h06;
    localparam logic [5:0] INT_HIGH_REG = 6'h07;
    localparam logic [5:0] CP_CURRENT_REG = 6'h09;
    localparam logic [5:0] REF_CTRL_REG = 6'h0A;
    localparam logic [5:0] OUT_DIV_REG = 6'h1C;
    // registers that only apply on a trigger write
    localparam logic [NREG-1:0] DBUF_MASK = 34'h100006EF;
    // field positions
    localparam int FRACTIONAL_VALUE_TOP_BIT = 0;
    localparam int REF_DIV_EN_BIT = 4;
    localparam int CP_MSB = 7;
    localparam int CP_LSB = 4;
    localparam int INT_HIGH_MSB = 3;
    localparam int REF_CTRL_MSB = 6;
    localparam int OUT_DIV_MSB = 2;

    typedef enum logic [3:0] {
        D_IDLE, D_ADDR, D_ACK_A, D_SUB, D_ACK_S,
        D_WDATA, D_ACK_W, D_RDATA, D_RACK, D_RNEXT
    } dscp_dst_t;
    typedef enum logic [2:0] {
        H_IDLE, H_LOCK, H_I2C, H_CSLO, H_SPI, H_CSHI, H_DONE
    } dscp_hst_t;
    typedef enum logic [1:0] {K_START, K_TX, K_RX, K_STOP} dscp_kind_t;
    typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_LOCK} dscp_op_t;
endpackage
